//--- core/ptc_pkg.sv
// Package of offsets, fields, reset values and types for the tick counter
package ptc_pkg;
    // Register word indices; byte address is four times the index
    localparam logic [13:0] IDX_SC1 = 14'h306A;
    localparam logic [13:0] IDX_SC2 = 14'h306B;
    localparam logic [13:0] IDX_LIM_HI = 14'h306C;
    localparam logic [13:0] IDX_LIM_LO = 14'h306D;
    localparam logic [13:0] IDX_CNT_HI = 14'h306E;
    localparam logic [13:0] IDX_CNT_LO = 14'h306F;
    // Field positions
    localparam int FLAG_BIT = 7;
    localparam int IRQ_EN_BIT = 6;
    localparam int TOG_EN_BIT = 4;
    localparam int SRC_HI = 7;
    localparam int SRC_LO = 6;
    localparam int DIV_HI = 2;
    localparam int DIV_LO = 0;
    // Source select codes and the divider off code
    localparam logic [1:0] SRC_EXT = 2'h0;
    localparam logic [1:0] SRC_LPO = 2'h1;
    localparam logic [2:0] DIV_OFF = 3'h0;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    // Decimal divide ratios of the x1 source group
    localparam logic [11:0] DIV_DEC_LO = 12'h064;
    localparam logic [11:0] DIV_DEC_HI = 12'h3E8;
    // Binary ratio exponent offset of the x1 source group
    localparam int BIN_X1_SHIFT = 7;

    typedef struct packed {
        logic irq_en;
        logic tog_en;
        logic [1:0] src;
        logic [2:0] div;
    } ptc_ctrl_s;

    localparam ptc_ctrl_s CTRL_RST = '{1'b0, 1'b0, 2'h0, 3'h0};

    // Divide ratio for a nonzero divider code; zero means stopped
    function automatic logic [11:0] div_ratio(input logic [2:0] code,
                                              input logic src_lo);
        logic [11:0] r;
        r = 12'h000;
        if (code != DIV_OFF) begin
            if (!src_lo) begin
                r = 12'(12'h001 << (code - 3'h1));
            end else if (code == 3'h6) begin
                r = DIV_DEC_LO;
            end else if (code == 3'h7) begin
                r = DIV_DEC_HI;
            end else begin
                r = 12'(12'h001 << (int'(code) - 1 + BIN_X1_SHIFT));
            end
        end
        return r;
    endfunction
endpackage

//--- core/ptc_regs.sv
// Periodic tick counter with classic Wishbone register slave
//
// Design decision made here: register access over Wishbone.
module ptc_regs #(
    parameter int ADR_W = 16,
    parameter int PRE_W = 11
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic ext_clk_i,
    input wire logic lpo_clk_i,
    output logic irq_o,
    output logic toggle_o
);
    initial begin
        if (ADR_W < 16 || PRE_W < 11) begin
            $error("ptc_regs: ADR_W must be >= 16 and PRE_W >= 11");
        end
    end

    ptc_pkg::ptc_ctrl_s ctrl;
    logic match_flag;
    logic [15:0] limit;
    logic [15:0] limit_act;
    logic [15:0] count_value;
    logic [7:0] count_hi_hold;
    logic [PRE_W-1:0] pre_cnt;
    logic [2:0] ext_sync;
    logic [2:0] lpo_sync;

    // Bus decode; writes take effect on the edge where the master sees ack
    logic [13:0] idx;
    logic acc;
    logic wr_lane;
    logic wr_sc1;
    logic wr_sc2;
    logic wr_lim_hi;
    logic wr_lim_lo;
    logic rd_cnt_lo;
    logic sel_change;
    logic src_tick;
    logic pre_tick;
    logic ovf;
    logic [11:0] ratio;
    logic [7:0] next_rdata;

    assign idx = adr_i[15:2];
    assign acc = cyc_i && stb_i && ack_o;
    assign wr_lane = acc && we_i && sel_i[0];
    assign wr_sc1 = wr_lane && idx == ptc_pkg::IDX_SC1;
    assign wr_sc2 = wr_lane && idx == ptc_pkg::IDX_SC2;
    assign wr_lim_hi = wr_lane && idx == ptc_pkg::IDX_LIM_HI;
    assign wr_lim_lo = wr_lane && idx == ptc_pkg::IDX_LIM_LO;
    // Freeze on the edge that loads the low byte, so both halves agree
    assign rd_cnt_lo = cyc_i && stb_i && !ack_o && !we_i &&
        idx == ptc_pkg::IDX_CNT_LO;
    assign sel_change = wr_sc2 &&
        (dat_i[ptc_pkg::SRC_HI:ptc_pkg::SRC_LO] != ctrl.src ||
         dat_i[ptc_pkg::DIV_HI:ptc_pkg::DIV_LO] != ctrl.div);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
        end
    end

    // Pins from other clocks pass two flops; third stage only for the edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_sync <= 3'h0;
            lpo_sync <= 3'h0;
        end else begin
            ext_sync <= {ext_sync[1:0], ext_clk_i};
            lpo_sync <= {lpo_sync[1:0], lpo_clk_i};
        end
    end

    always_comb begin
        unique case (ctrl.src)
            ptc_pkg::SRC_EXT: src_tick = ext_sync[1] && !ext_sync[2];
            ptc_pkg::SRC_LPO: src_tick = lpo_sync[1] && !lpo_sync[2];
            default: src_tick = 1'b1;
        endcase
    end

    assign ratio = ptc_pkg::div_ratio(ctrl.div, ctrl.src[0]);
    assign pre_tick = ctrl.div != ptc_pkg::DIV_OFF && src_tick &&
        pre_cnt == PRE_W'(ratio - 12'h001);
    assign ovf = pre_tick && count_value == limit_act;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= ptc_pkg::CTRL_RST;
        end else begin
            if (wr_sc1) begin
                ctrl.irq_en <= dat_i[ptc_pkg::IRQ_EN_BIT];
                ctrl.tog_en <= dat_i[ptc_pkg::TOG_EN_BIT];
            end
            if (wr_sc2) begin
                ctrl.src <= dat_i[ptc_pkg::SRC_HI:ptc_pkg::SRC_LO];
                ctrl.div <= dat_i[ptc_pkg::DIV_HI:ptc_pkg::DIV_LO];
            end
        end
    end

    // Prescaler; a source or divider change restarts it from zero
    always_ff @(posedge clk_i) begin
        if (rst_i || sel_change) begin
            pre_cnt <= '0;
        end else if (ctrl.div == ptc_pkg::DIV_OFF) begin
            pre_cnt <= '0;
        end else if (pre_tick) begin
            pre_cnt <= '0;
        end else if (src_tick) begin
            pre_cnt <= pre_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || sel_change) begin
            count_value <= ptc_pkg::RST_WORD;
        end else if (ovf) begin
            count_value <= ptc_pkg::RST_WORD;
        end else if (pre_tick) begin
            count_value <= count_value + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            limit <= ptc_pkg::RST_WORD;
        end else begin
            if (wr_lim_hi) begin
                limit[15:8] <= dat_i[7:0];
            end
            if (wr_lim_lo) begin
                limit[7:0] <= dat_i[7:0];
            end
        end
    end

    // Shadowed limit so byte writes reach the compare only at start or at the next overflow
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            limit_act <= ptc_pkg::RST_WORD;
        end else if (wr_sc2 && dat_i[ptc_pkg::DIV_HI:ptc_pkg::DIV_LO]
                     != ptc_pkg::DIV_OFF) begin
            limit_act <= limit;
        end else if (ovf) begin
            limit_act <= limit;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            match_flag <= 1'b0;
        end else if (ovf) begin
            match_flag <= 1'b1;
        end else if (wr_sc1 && dat_i[ptc_pkg::FLAG_BIT]) begin
            match_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= match_flag && ctrl.irq_en;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            toggle_o <= 1'b0;
        end else if (ovf && ctrl.tog_en) begin
            toggle_o <= !toggle_o;
        end
    end

    // Low byte read freezes the high byte for a coherent pair
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_hi_hold <= ptc_pkg::RST_BYTE;
        end else if (rd_cnt_lo) begin
            count_hi_hold <= count_value[15:8];
        end
    end

    always_comb begin
        next_rdata = ptc_pkg::RST_BYTE;
        unique case (idx)
            ptc_pkg::IDX_SC1: begin
                next_rdata[ptc_pkg::FLAG_BIT] = match_flag;
                next_rdata[ptc_pkg::IRQ_EN_BIT] = ctrl.irq_en;
                next_rdata[ptc_pkg::TOG_EN_BIT] = ctrl.tog_en;
            end
            ptc_pkg::IDX_SC2: begin
                next_rdata[ptc_pkg::SRC_HI:ptc_pkg::SRC_LO] = ctrl.src;
                next_rdata[ptc_pkg::DIV_HI:ptc_pkg::DIV_LO] = ctrl.div;
            end
            ptc_pkg::IDX_LIM_HI: next_rdata = limit[15:8];
            ptc_pkg::IDX_LIM_LO: next_rdata = limit[7:0];
            ptc_pkg::IDX_CNT_HI: next_rdata = count_hi_hold;
            ptc_pkg::IDX_CNT_LO: next_rdata = count_value[7:0];
            default: next_rdata = ptc_pkg::RST_BYTE;
        endcase
    end

    // Unmapped addresses answer with zero, never hang the bus
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h00000000;
        end else if (cyc_i && stb_i && !ack_o) begin
            dat_o <= {24'h000000, next_rdata};
        end
    end

    chk_flag_set: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ovf |=> match_flag)
        else $error("match flag not set after overflow");

    chk_flag_clear: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_sc1 && dat_i[7] && !ovf |=> !match_flag)
        else $error("match flag not cleared by write of one");

    chk_flag_keep: assert property (
        @(posedge clk_i) disable iff (rst_i)
        match_flag && !(wr_sc1 && dat_i[7]) |=> match_flag)
        else $error("match flag dropped without clear");

    chk_irq_follow: assert property (
        @(posedge clk_i) disable iff (rst_i)
        irq_o == $past(match_flag && ctrl.irq_en))
        else $error("interrupt does not follow flag and enable");

    chk_irq_quiet: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !ctrl.irq_en |=> !irq_o)
        else $error("interrupt raised while disabled");

    chk_irq_drop: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !match_flag |=> !irq_o)
        else $error("interrupt stands without flag");

    chk_pin_toggle: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ovf && ctrl.tog_en |=> toggle_o != $past(toggle_o))
        else $error("output pin did not toggle on overflow");

    chk_pin_still: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(ovf && ctrl.tog_en) |=> $stable(toggle_o))
        else $error("output pin changed without overflow");

    chk_resv_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ack_o && idx == ptc_pkg::IDX_SC1 && $past(idx) == idx
        |-> dat_o[5] == 1'b0 && dat_o[3:0] == 4'h0)
        else $error("reserved control bits read nonzero");

    chk_sc2_resv: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ack_o && idx == ptc_pkg::IDX_SC2 && $past(idx) == idx
        |-> dat_o[5:3] == 3'h0)
        else $error("reserved select bits read nonzero");

    chk_upper_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ack_o |-> dat_o[31:8] == 24'h000000)
        else $error("upper read lanes not zero");

    chk_src_bus: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ctrl.src[1] |-> src_tick)
        else $error("bus clock source did not tick");

    chk_sel_keep: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !wr_sc2 |=> $stable(ctrl.src) && $stable(ctrl.div))
        else $error("selects changed without a write");

    chk_sel_clear: assert property (
        @(posedge clk_i) disable iff (rst_i)
        sel_change |=> count_value == 16'h0000 && pre_cnt == '0)
        else $error("select change did not clear counters");

    chk_pre_stop: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ctrl.div == ptc_pkg::DIV_OFF |=> pre_cnt == '0)
        else $error("prescaler ran while stopped");

    chk_count_hold: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ctrl.div == 3'h0 && !sel_change |=> $stable(count_value))
        else $error("count moved while prescaler off");

    chk_count_step: assert property (
        @(posedge clk_i) disable iff (rst_i)
        pre_tick && !ovf && !sel_change
        |=> count_value == $past(count_value) + 16'h0001)
        else $error("count did not step on prescaler tick");

    chk_count_wrap: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ovf && !sel_change |=> count_value == 16'h0000)
        else $error("count not zero after match");

    chk_limit_zero: assert property (
        @(posedge clk_i) disable iff (rst_i)
        pre_tick && limit_act == 16'h0000 |=> match_flag)
        else $error("zero limit did not flag on tick");

    chk_limit_latch: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !ovf && !wr_sc2 |=> $stable(limit_act))
        else $error("active limit changed early");

    chk_limit_load: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ovf && !wr_sc2 |=> limit_act == $past(limit))
        else $error("active limit not loaded at overflow");

    chk_limit_write: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wr_lim_lo |=> limit[7:0] == $past(dat_i[7:0]))
        else $error("limit low byte write lost");

    chk_hold_latch: assert property (
        @(posedge clk_i) disable iff (rst_i)
        rd_cnt_lo |=> count_hi_hold == $past(count_value[15:8]))
        else $error("high count byte not frozen with low read");

    chk_ack_answer: assert property (
        @(posedge clk_i) disable iff (rst_i)
        cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered next cycle");

    chk_ack_pulse: assert property (
        @(posedge clk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    cov_overflow: cover property (@(posedge clk_i) disable iff (rst_i)
        ovf && limit_act != 16'h0000);
    cov_zero_limit: cover property (@(posedge clk_i) disable iff (rst_i)
        ovf && limit_act == 16'h0000);
    cov_set_clear: cover property (@(posedge clk_i) disable iff (rst_i)
        ovf && wr_sc1 && dat_i[7]);
    cov_pin_toggle: cover property (@(posedge clk_i) disable iff (rst_i)
        ovf && ctrl.tog_en && irq_o);
endmodule // ptc_regs

//--- verif/ptc_tb.sv
// Self-checking testbench for the periodic tick counter register block
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat_w = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic ext_clk = 1'b0;
    logic lpo_clk = 1'b0;
    logic irq_o;
    logic toggle_o;
    logic [7:0] rq;
    logic [15:0] cnt;
    int bad_count = 0;
    int total_checks = 0;
    // Expected divide ratios, bus source x0 group then x1 group
    int rat[14] = '{1, 2, 4, 8, 16, 32, 64, 128, 256, 512, 1024, 2048,
                    100, 1000};

    ptc_regs i_ptc_regs (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w),
        .dat_o(dat_o), .ack_o(ack_o), .ext_clk_i(ext_clk),
        .lpo_clk_i(lpo_clk), .irq_o(irq_o), .toggle_o(toggle_o));

    always #50 clk_i = ~clk_i;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic single cycle; the wait for ack has no bound, n only counts cycles
    task automatic wb(input logic w, input logic [13:0] idx,
                      input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat_w <= {24'h0, d};
        sel <= 4'hF;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1);
        check({31'h0, ack_o}, 32'h1);
        rq = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rd(input logic [13:0] idx, input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        check({24'h0, rq}, {24'h0, exp});
    endtask

    // Low byte first so the high byte is frozen with it
    task automatic rdcnt();
        wb(1'b0, ptc_pkg::IDX_CNT_LO, 8'h00);
        cnt[7:0] = rq;
        wb(1'b0, ptc_pkg::IDX_CNT_HI, 8'h00);
        cnt[15:8] = rq;
    endtask

    task automatic t_reset();
        for (int i = 0; i < 6; i++) begin
            rd(ptc_pkg::IDX_SC1 + 14'(i), 8'h00);
        end
        check({31'h0, irq_o}, 32'h0);
        check({31'h0, toggle_o}, 32'h0);
        $display("reset values done");
    endtask

    task automatic t_regs();
        wb(1'b1, ptc_pkg::IDX_SC1, 8'hFF);
        rd(ptc_pkg::IDX_SC1, 8'h50);
        wb(1'b1, ptc_pkg::IDX_SC2, 8'hFF);
        rd(ptc_pkg::IDX_SC2, 8'hC7);
        wb(1'b1, ptc_pkg::IDX_SC2, 8'h00);
        wb(1'b1, ptc_pkg::IDX_SC1, 8'h00);
        wb(1'b1, ptc_pkg::IDX_CNT_HI, 8'hFF);
        wb(1'b1, ptc_pkg::IDX_CNT_LO, 8'hFF);
        rdcnt();
        check({16'h0, cnt}, 32'h0);
        wb(1'b1, 14'h3070, 8'hAA);
        rd(14'h3070, 8'h00);
        wb(1'b1, ptc_pkg::IDX_LIM_HI, 8'h12);
        wb(1'b1, ptc_pkg::IDX_LIM_LO, 8'h34);
        rd(ptc_pkg::IDX_LIM_HI, 8'h12);
        rd(ptc_pkg::IDX_LIM_LO, 8'h34);
        $display("register access done");
    endtask

    task automatic t_match();
        wb(1'b1, ptc_pkg::IDX_LIM_HI, 8'h00);
        wb(1'b1, ptc_pkg::IDX_LIM_LO, 8'h03);
        wb(1'b1, ptc_pkg::IDX_SC1, 8'h40);
        wb(1'b1, ptc_pkg::IDX_SC2, 8'h81);
        repeat (20) @(posedge clk_i);
        rdcnt();
        check({31'h0, cnt <= 16'h0003}, 32'h1);
        rd(ptc_pkg::IDX_SC1, 8'hC0);
        check({31'h0, irq_o}, 32'h1);
        wb(1'b1, ptc_pkg::IDX_SC2, 8'h80);
        rdcnt();
        check({16'h0, cnt}, 32'h0);
        repeat (10) @(posedge clk_i);
        rdcnt();
        check({16'h0, cnt}, 32'h0);
        wb(1'b1, ptc_pkg::IDX_SC1, 8'h40);
        rd(ptc_pkg::IDX_SC1, 8'hC0);
        wb(1'b1, ptc_pkg::IDX_SC1, 8'hC0);
        rd(ptc_pkg::IDX_SC1, 8'h40);
        check({31'h0, irq_o}, 32'h0);
        wb(1'b1, ptc_pkg::IDX_SC1, 8'h00);
        // Limit zero flags every prescaler tick while the count stays 0
        wb(1'b1, ptc_pkg::IDX_LIM_LO, 8'h00);
        wb(1'b1, ptc_pkg::IDX_SC2, 8'h81);
        repeat (5) @(posedge clk_i);
        rd(ptc_pkg::IDX_SC1, 8'h80);
        check({31'h0, irq_o}, 32'h0);
        $display("match and flag done");
    endtask

    task automatic t_ratio();
        wb(1'b1, ptc_pkg::IDX_LIM_HI, 8'hFF);
        wb(1'b1, ptc_pkg::IDX_LIM_LO, 8'hFF);
        wb(1'b1, ptc_pkg::IDX_SC2, 8'h00);
        for (int k = 0; k < 14; k++) begin
            wb(1'b1, ptc_pkg::IDX_SC2, {(k < 7) ? 2'h2 : 2'h3, 3'h0,
                                       3'(k % 7 + 1)});
            repeat (rat[k] * 12) @(posedge clk_i);
            rdcnt();
            check({31'h0, cnt >= 16'h000B && cnt <= 16'h000E},
                  32'h1);
        end
        // A changed source alone must zero the count
        wb(1'b1, ptc_pkg::IDX_SC2, 8'h81);
        repeat (50) @(posedge clk_i);
        wb(1'b1, ptc_pkg::IDX_SC2, 8'hC1);
        rdcnt();
        check({16'h0, cnt}, 32'h0);
        $display("divider ratios done");
    endtask

    task automatic toggles(input int span, output int n);
        logic prev;
        n = 0;
        // Let the edge that ended the last write settle first
        @(posedge clk_i);
        prev = toggle_o;
        repeat (span) begin
            @(posedge clk_i);
            if (toggle_o !== prev) n++;
            prev = toggle_o;
        end
    endtask

    task automatic t_toggle();
        int n;
        wb(1'b1, ptc_pkg::IDX_SC2, 8'h00);
        wb(1'b1, ptc_pkg::IDX_LIM_HI, 8'h00);
        wb(1'b1, ptc_pkg::IDX_LIM_LO, 8'h03);
        wb(1'b1, ptc_pkg::IDX_SC1, 8'h10);
        wb(1'b1, ptc_pkg::IDX_SC2, 8'h81);
        toggles(400, n);
        check({31'h0, n >= 99 && n <= 101}, 32'h1);
        // New limit is picked up at the next overflow without a restart
        wb(1'b1, ptc_pkg::IDX_LIM_LO, 8'h07);
        repeat (20) @(posedge clk_i);
        toggles(400, n);
        check({31'h0, n >= 49 && n <= 51}, 32'h1);
        wb(1'b1, ptc_pkg::IDX_SC1, 8'h00);
        toggles(100, n);
        check(n, 0);
        $display("toggle output done");
    endtask

    // Slow pulses on both source pins; only the selected one may count
    task automatic pins(input int ne, input int nl);
        for (int i = 0; i < ((ne > nl) ? ne : nl); i++) begin
            ext_clk <= (i < ne);
            lpo_clk <= (i < nl);
            repeat (3) @(posedge clk_i);
            ext_clk <= 1'b0;
            lpo_clk <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
        repeat (6) @(posedge clk_i);
    endtask

    task automatic t_pins();
        wb(1'b1, ptc_pkg::IDX_LIM_HI, 8'hFF);
        wb(1'b1, ptc_pkg::IDX_SC2, 8'h00);
        wb(1'b1, ptc_pkg::IDX_SC2, 8'h01);
        pins(12, 5);
        rdcnt();
        check({16'h0, cnt}, 32'h0000000C);
        wb(1'b1, ptc_pkg::IDX_SC2, 8'h46);
        pins(10, 250);
        rdcnt();
        check({16'h0, cnt}, 32'h00000002);
        $display("source pins done");
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_regs();
        t_match();
        t_ratio();
        t_toggle();
        t_pins();
        // A second reset mid-run must restore every register
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        finish_test();
    end

    // Tests need about 65000 cycles
    initial begin
        repeat (95000) @(posedge clk_i);
        bad_count++;
        finish_test();
    end
endmodule // testbench
